//--- odtu_pkg.sv
package odtu_pkg;

  // ----------------------------------------------------------------
  // Widths and bit positions
  // ----------------------------------------------------------------
  localparam int          ODTU_WORD_W    = 16;
  localparam int          ODTU_BYTE_W    = 8;
  localparam int          ODTU_WSIGN_BIT = 15;
  localparam int          ODTU_BSIGN_BIT = 7;
  localparam int          ODTU_SEL_BIT   = 0;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [15:0] ODTU_WORD_STEP = 16'h0002;
  localparam logic [15:0] ODTU_ZERO_W    = 16'h0000;
  localparam logic [7:0]  ODTU_ZERO_B    = 8'h00;
  localparam logic [15:0] ODTU_ALIGN_MSK = 16'hFFFE;
  localparam int          ODTU_SET_SIZE  = 256;

  // ----------------------------------------------------------------
  // Arithmetic operation codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ODTU_OP_ADD = 2'h0,
    ODTU_OP_SUB = 2'h1,
    ODTU_OP_CMP = 2'h2
  } odtu_op_t;

  // ----------------------------------------------------------------
  // Descriptor kinds
  // ----------------------------------------------------------------
  localparam logic        ODTU_KIND_STR  = 1'b0;
  localparam logic        ODTU_KIND_SET  = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ODTU_ST_IDLE = 5'h01,
    ODTU_ST_RD0  = 5'h02,
    ODTU_ST_RD1  = 5'h04,
    ODTU_ST_SET  = 5'h08,
    ODTU_ST_DONE = 5'h10
  } odtu_state_t;

endpackage

//--- odtu_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Signed values use two's complement, sign top
// - Byte signed: bit 7 sign, -128..127
// - Byte unsigned add/sub/compare, 0..255
// - Word signed: bit 15 sign, -32768..32767
// - Word unsigned add/sub/compare, 0..65535
// - Word address is its low-order byte
// - String located by lowest, most significant address
// - Descriptor: unsigned 16-bit length plus address
// - Zero length string: address ignored
// - Descriptor from register pair or memory pointer
// - Set descriptor: table base and mask
// - Member when table byte AND mask nonzero
// - Each mask bit selects one subset
module odtu_unit
  import odtu_pkg::*;
#(
  parameter int W = ODTU_WORD_W,
  parameter int B = ODTU_BYTE_W
) (
  // Clock and reset
  input  wire logic         I_CLOCK,
  input  wire logic         I_ARST_N,
  // Integer arithmetic request
  input  wire logic         I_ALU_VALID,
  input  wire logic [1:0]   I_ALU_OP,
  input  wire logic         I_ALU_BYTE,
  input  wire logic         I_ALU_SIGNED,
  input  wire logic [W-1:0] I_ALU_A,
  input  wire logic [W-1:0] I_ALU_B,
  // Integer arithmetic answer
  output logic              O_ALU_VALID,
  output logic [W-1:0]      O_ALU_RESULT,
  output logic              O_ALU_N,
  output logic              O_ALU_Z,
  output logic              O_ALU_V,
  output logic              O_ALU_C,
  output logic              O_ALU_LESS,
  // Character operand check
  input  wire logic [W-1:0] I_CHAR_OPND,
  output logic [B-1:0]      O_CHAR_CODE,
  output logic              O_CHAR_BAD,
  // Descriptor load
  input  wire logic         I_DESC_START,
  input  wire logic         I_DESC_KIND,
  input  wire logic         I_DESC_INLINE,
  input  wire logic [W-1:0] I_GENERAL_REGISTER_N,
  input  wire logic [W-1:0] I_GENERAL_REGISTER_N1,
  input  wire logic [W-1:0] I_DESC_PTR,
  // Descriptor result
  output logic              O_DESC_DONE,
  output logic [W-1:0]      O_STR_LEN,
  output logic [W-1:0]      O_STR_ADDR,
  output logic              O_STR_VACANT,
  output logic [B-1:0]      O_SET_MASK,
  output logic [W-1:0]      O_SET_BASE,
  output logic              O_SET_DESC_BAD,
  // Membership test
  input  wire logic         I_SET_START,
  input  wire logic [B-1:0] I_SET_CHAR,
  output logic              O_MEMBER_VALID,
  output logic              O_MEMBER,
  output logic              O_BUSY,
  // Memory read port
  output logic              O_MEM_REQ,
  output logic [W-1:0]      O_MEM_ADDR,
  input  wire logic         I_MEM_ACK,
  input  wire logic [W-1:0] I_MEM_RDATA
);

  // ----------------------------------------------------------------
  // Integer datapath
  // ----------------------------------------------------------------

  // Subtract and compare add the inverted operand plus one
  logic         w_sub;
  logic [W-1:0] w_b_eff;
  logic [W:0]   w_wsum;
  logic [B:0]   w_bsum;
  assign w_sub   = (I_ALU_OP == ODTU_OP_SUB) || (I_ALU_OP == ODTU_OP_CMP);
  assign w_b_eff = w_sub ? ~I_ALU_B : I_ALU_B;
  assign w_wsum  = {1'b0, I_ALU_A} + {1'b0, w_b_eff} + {{W{1'b0}}, w_sub};
  assign w_bsum  = {1'b0, I_ALU_A[B-1:0]} + {1'b0, w_b_eff[B-1:0]} + {{B{1'b0}}, w_sub};

  // Byte mode keeps the result in the low half, upper half zero
  logic [W-1:0] w_res;
  logic         w_cout;
  logic         w_sa;
  logic         w_sb;
  logic         w_sr;
  assign w_res  = I_ALU_BYTE ? {{(W-B){1'b0}}, w_bsum[B-1:0]} : w_wsum[W-1:0];
  assign w_cout = I_ALU_BYTE ? w_bsum[B] : w_wsum[W];
  assign w_sa   = I_ALU_BYTE ? I_ALU_A[ODTU_BSIGN_BIT] : I_ALU_A[ODTU_WSIGN_BIT];
  assign w_sb   = I_ALU_BYTE ? w_b_eff[ODTU_BSIGN_BIT] : w_b_eff[ODTU_WSIGN_BIT];
  assign w_sr   = I_ALU_BYTE ? w_bsum[ODTU_BSIGN_BIT] : w_wsum[ODTU_WSIGN_BIT];

  // Flags: carry means borrow for subtract and compare
  logic w_n;
  logic w_z;
  logic w_v;
  logic w_c;
  logic w_less;
  assign w_n    = w_sr;
  assign w_z    = (w_res == ODTU_ZERO_W);
  assign w_v    = (w_sa == w_sb) && (w_sr != w_sa);
  assign w_c    = w_sub ? ~w_cout : w_cout;
  // Signed order from N xor V, unsigned order from the borrow
  assign w_less = I_ALU_SIGNED ? (w_n ^ w_v) : w_c;

  // Result registers; compare still reports the difference
  logic         alu_valid_q;
  logic [W-1:0] alu_res_q;
  logic [4:0]   alu_flags_q;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      alu_valid_q <= 1'b0;
      alu_res_q   <= '0;
      alu_flags_q <= '0;
    end else begin
      alu_valid_q <= I_ALU_VALID;
      if (I_ALU_VALID) begin
        alu_res_q   <= w_res;
        alu_flags_q <= {w_n, w_z, w_v, w_c, w_less};
      end
    end
  end

  // ----------------------------------------------------------------
  // Character operand check
  // ----------------------------------------------------------------

  // Flag only; a nonzero upper half is the caller's fault
  logic [B-1:0] char_code_q;
  logic         char_bad_q;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      char_code_q <= '0;
      char_bad_q  <= 1'b0;
    end else begin
      char_code_q <= I_CHAR_OPND[B-1:0];
      char_bad_q  <= (I_CHAR_OPND[W-1:B] != {(W-B){1'b0}});
    end
  end

  // ----------------------------------------------------------------
  // Descriptor and membership sequencer
  // ----------------------------------------------------------------

  // Byte fetch: word at the even address, low byte at the lower one
  function automatic logic [B-1:0] pick_byte(input logic [W-1:0] adr,
                                              input logic [W-1:0] data);
    pick_byte = adr[ODTU_SEL_BIT] ? data[W-1:B] : data[B-1:0];
  endfunction

  odtu_state_t  state_q;
  odtu_state_t  state_d;
  logic         kind_q;
  logic [W-1:0] ptr_q;
  logic [W-1:0] w0_q;
  logic [W-1:0] w1_q;
  logic [W-1:0] tadr_q;
  logic         member_q;
  logic         member_v_q;
  logic         done_q;
  logic         mreq_q;
  logic [W-1:0] maddr_q;
  logic         busy_q;

  // Table entry address: base plus character code, wrapping
  logic [W-1:0] w_tadr;
  logic [B-1:0] w_tbyte;
  logic         w_hit;
  assign w_tadr  = O_SET_BASE + {{(W-B){1'b0}}, I_SET_CHAR};
  assign w_tbyte = pick_byte(tadr_q, I_MEM_RDATA);
  // Mask bits pick subsets; any surviving bit means member
  assign w_hit   = ((w_tbyte & O_SET_MASK) != ODTU_ZERO_B);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ODTU_ST_IDLE: begin
        if (I_DESC_START && I_DESC_INLINE) begin
          state_d = ODTU_ST_RD0;
        end else if (I_DESC_START) begin
          state_d = ODTU_ST_DONE;
        end else if (I_SET_START) begin
          state_d = ODTU_ST_SET;
        end
      end
      ODTU_ST_RD0: begin
        if (I_MEM_ACK) begin
          state_d = ODTU_ST_RD1;
        end
      end
      ODTU_ST_RD1: begin
        if (I_MEM_ACK) begin
          state_d = ODTU_ST_DONE;
        end
      end
      ODTU_ST_SET: begin
        if (I_MEM_ACK) begin
          state_d = ODTU_ST_IDLE;
        end
      end
      ODTU_ST_DONE: begin
        state_d = ODTU_ST_IDLE;
      end
      default: begin
        state_d = ODTU_ST_IDLE;
      end
    endcase
  end

  // State, descriptor words and memory request
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= ODTU_ST_IDLE;
      kind_q  <= ODTU_KIND_STR;
      ptr_q   <= '0;
      w0_q    <= '0;
      w1_q    <= '0;
      tadr_q  <= '0;
      mreq_q  <= 1'b0;
      maddr_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      // Busy taken from the next state so the port stays a plain flop
      busy_q  <= (state_d != ODTU_ST_IDLE);
      if (state_q == ODTU_ST_IDLE && I_DESC_START) begin
        kind_q <= I_DESC_KIND;
        ptr_q  <= I_DESC_PTR;
        if (I_DESC_INLINE) begin
          mreq_q  <= 1'b1;
          maddr_q <= I_DESC_PTR & ODTU_ALIGN_MSK;
        end else begin
          w0_q <= I_GENERAL_REGISTER_N;
          w1_q <= I_GENERAL_REGISTER_N1;
        end
      end else if (state_q == ODTU_ST_IDLE && I_SET_START) begin
        tadr_q  <= w_tadr;
        mreq_q  <= 1'b1;
        maddr_q <= w_tadr & ODTU_ALIGN_MSK;
      end else if (state_q == ODTU_ST_RD0 && I_MEM_ACK) begin
        w0_q    <= I_MEM_RDATA;
        maddr_q <= (ptr_q + ODTU_WORD_STEP) & ODTU_ALIGN_MSK;
      end else if (I_MEM_ACK && mreq_q) begin
        if (state_q == ODTU_ST_RD1) begin
          w1_q <= I_MEM_RDATA;
        end
        mreq_q <= 1'b0;
      end
    end
  end

  // Published descriptor fields, updated as the load completes
  logic [W-1:0] str_len_q;
  logic [W-1:0] str_addr_q;
  logic         str_vac_q;
  logic [B-1:0] set_mask_q;
  logic [W-1:0] set_base_q;
  logic         set_bad_q;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      done_q     <= 1'b0;
      str_len_q  <= '0;
      str_addr_q <= '0;
      str_vac_q  <= 1'b1;
      set_mask_q <= '0;
      set_base_q <= '0;
      set_bad_q  <= 1'b0;
    end else begin
      done_q <= (state_q == ODTU_ST_DONE);
      if (state_q == ODTU_ST_DONE && kind_q == ODTU_KIND_STR) begin
        str_len_q  <= w0_q;
        str_vac_q  <= (w0_q == ODTU_ZERO_W);
        // Vacant string shows no address so nothing downstream uses it
        str_addr_q <= (w0_q == ODTU_ZERO_W) ? ODTU_ZERO_W : w1_q;
      end
      if (state_q == ODTU_ST_DONE && kind_q == ODTU_KIND_SET) begin
        set_mask_q <= w0_q[B-1:0];
        set_base_q <= w1_q;
        set_bad_q  <= (w0_q[W-1:B] != {(W-B){1'b0}});
      end
    end
  end

  // Membership answer lands one cycle after the table byte
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      member_q   <= 1'b0;
      member_v_q <= 1'b0;
    end else begin
      member_v_q <= (state_q == ODTU_ST_SET) && I_MEM_ACK;
      if (state_q == ODTU_ST_SET && I_MEM_ACK) begin
        member_q <= w_hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign O_ALU_VALID    = alu_valid_q;
  assign O_ALU_RESULT   = alu_res_q;
  assign O_ALU_N        = alu_flags_q[4];
  assign O_ALU_Z        = alu_flags_q[3];
  assign O_ALU_V        = alu_flags_q[2];
  assign O_ALU_C        = alu_flags_q[1];
  assign O_ALU_LESS     = alu_flags_q[0];
  assign O_CHAR_CODE    = char_code_q;
  assign O_CHAR_BAD     = char_bad_q;
  assign O_DESC_DONE    = done_q;
  assign O_STR_LEN      = str_len_q;
  assign O_STR_ADDR     = str_addr_q;
  assign O_STR_VACANT   = str_vac_q;
  assign O_SET_MASK     = set_mask_q;
  assign O_SET_BASE     = set_base_q;
  assign O_SET_DESC_BAD = set_bad_q;
  assign O_MEMBER_VALID = member_v_q;
  assign O_MEMBER       = member_q;
  assign O_BUSY         = busy_q;
  assign O_MEM_REQ      = mreq_q;
  assign O_MEM_ADDR     = maddr_q;

endmodule

`default_nettype wire

//--- odtu_unit_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checker
// ------
module odtu_chk (
  // Clock, reset and requests
  input wire logic        I_CLOCK, I_ARST_N, I_ALU_VALID, I_ALU_BYTE,
  input wire logic        I_ALU_SIGNED, I_DESC_START, I_DESC_INLINE, I_MEM_ACK,
  input wire logic [1:0]  I_ALU_OP,
  input wire logic [15:0] I_ALU_A, I_ALU_B, I_CHAR_OPND,
  // Answers
  input wire logic        O_ALU_VALID, O_ALU_N, O_ALU_LESS, O_CHAR_BAD, O_BUSY,
  input wire logic        O_DESC_DONE, O_STR_VACANT, O_MEM_REQ, O_MEMBER_VALID,
  input wire logic [7:0]  O_CHAR_CODE,
  input wire logic [15:0] O_ALU_RESULT, O_STR_ADDR, O_MEM_ADDR
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  // Arithmetic answer timing and values
  chk_alu_answer: assert property (I_ALU_VALID |=> O_ALU_VALID)
    else $error("Arithmetic answer missing");
  chk_word_sum: assert property (I_ALU_VALID && I_ALU_OP == 2'h0 && !I_ALU_BYTE
    |=> O_ALU_RESULT == $past(16'(I_ALU_A + I_ALU_B))) else $error("Word sum wrong");
  chk_word_less: assert property (I_ALU_VALID && I_ALU_OP inside {2'h1, 2'h2} && !I_ALU_BYTE
    |=> O_ALU_LESS == $past(I_ALU_SIGNED ? $signed(I_ALU_A) < $signed(I_ALU_B)
    : I_ALU_A < I_ALU_B)) else $error("Word ordering wrong");
  chk_sign_bit: assert property (O_ALU_VALID |-> O_ALU_N ==
    ($past(I_ALU_BYTE) ? O_ALU_RESULT[7] : O_ALU_RESULT[15])) else $error("Sign flag wrong");
  chk_byte_upper: assert property (O_ALU_VALID && $past(I_ALU_BYTE)
    |-> O_ALU_RESULT[15:8] == 8'h00) else $error("Byte result upper half set");
  // Skips the edge right after release, whose sample saw reset
  chk_char_split: assert property ($past(I_ARST_N) |=> O_CHAR_CODE == $past(I_CHAR_OPND[7:0])
    && O_CHAR_BAD == ($past(I_CHAR_OPND[15:8]) != 8'h00)) else $error("Character check wrong");
  // Descriptors and memory port
  chk_desc_done: assert property (I_DESC_START && !O_BUSY && !I_DESC_INLINE
    |-> ##2 O_DESC_DONE) else $error("Register descriptor late");
  chk_vacant_addr: assert property (O_STR_VACANT |-> O_STR_ADDR == 16'h0000)
    else $error("Vacant string shows an address");
  chk_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK
    |=> O_MEM_REQ && $stable(O_MEM_ADDR)) else $error("Memory request dropped");
  chk_addr_even: assert property (O_MEM_REQ |-> !O_MEM_ADDR[0])
    else $error("Odd memory word address");
  chk_member_time: assert property (O_MEMBER_VALID
    |-> $past(I_MEM_ACK) && !O_BUSY) else $error("Member result mistimed");
endmodule

bind odtu_unit odtu_chk u_chk (.*);
`default_nettype wire

//--- odtu_mem.sv
`timescale 1ns/1ps
`default_nettype none
module odtu_mem (
  // Clock, reset and pacing
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_wait,
  // Read port
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [1:0] cnt_q;
  // Table pattern mixes both address halves so wrong bases show
  function automatic logic [7:0] mbyte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  // Data churns outside the ack so stale reads cannot pass
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= 2'h0;
      o_ack   <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack && cnt_q == i_wait) begin
        o_ack   <= 1'b1;
        o_rdata <= {mbyte(i_addr | 16'h0001), mbyte(i_addr)};
        cnt_q   <= 2'h0;
      end else if (i_req && !o_ack) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- odtu_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module odtu_unit_tb;
  import odtu_pkg::*;
  logic I_CLOCK = 1'b0, I_ARST_N = 1'b0, I_ALU_VALID = 1'b0, I_ALU_BYTE = 1'b0;
  logic I_ALU_SIGNED = 1'b0, I_DESC_START = 1'b0, I_DESC_KIND = 1'b0;
  logic I_DESC_INLINE = 1'b0, I_SET_START = 1'b0;
  logic [1:0] I_ALU_OP = 2'h0, mwait = 2'h0;
  logic [15:0] I_ALU_A = 16'h0000, I_ALU_B = 16'h0000, I_CHAR_OPND = 16'h0000;
  logic [15:0] I_GENERAL_REGISTER_N = 16'h0000, I_GENERAL_REGISTER_N1 = 16'h0000;
  logic [15:0] I_DESC_PTR = 16'h0000;
  logic [7:0] I_SET_CHAR = 8'h00;
  logic I_MEM_ACK, O_ALU_VALID, O_ALU_N, O_ALU_Z, O_ALU_V, O_ALU_C, O_ALU_LESS;
  logic O_CHAR_BAD, O_DESC_DONE, O_STR_VACANT, O_SET_DESC_BAD, O_MEMBER_VALID;
  logic O_MEMBER, O_BUSY, O_MEM_REQ;
  logic [15:0] O_ALU_RESULT, O_STR_LEN, O_STR_ADDR, O_SET_BASE, O_MEM_ADDR, I_MEM_RDATA;
  logic [7:0] O_CHAR_CODE, O_SET_MASK;
  int fail_count = 0;
  int n_checks = 0;
  always #25 I_CLOCK = ~I_CLOCK;
  odtu_unit uut (.*);
  odtu_mem u_mem (.i_clk(I_CLOCK), .i_rst_n(I_ARST_N), .i_wait(mwait), .i_req(O_MEM_REQ),
    .i_addr(O_MEM_ADDR), .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));
  // ------
  // Helpers
  // ------
  function automatic logic [7:0] tb_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Checks made %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for a done pulse, sampled just after the edge
  task automatic wait_hi(input bit sel);
    int k;
    k = 0;
    do begin
      @(posedge I_CLOCK);
      #1;
      k++;
    end while ((sel ? O_MEMBER_VALID : O_DESC_DONE) !== 1'b1 && k < 40);
    chk("handshake", sel ? O_MEMBER_VALID : O_DESC_DONE, 1'b1);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_alu(input logic [1:0] op, input logic byt, sg, input logic [15:0] a, b);
    logic [15:0] r;
    logic lt;
    logic [16:0] ws;
    logic [8:0] bs;
    logic sub, sa, sb, sr, cy, ov;
    sub = op[0] ^ op[1];
    r = sub ? a - b : a + b;
    lt = sg ? $signed(a) < $signed(b) : a < b;
    if (byt) begin
      r[15:8] = 8'h00;
      lt = sg ? $signed(a[7:0]) < $signed(b[7:0]) : a[7:0] < b[7:0];
    end
    // Carry out of the add, borrow out of the subtract
    ws = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    bs = sub ? {1'b0, a[7:0]} - {1'b0, b[7:0]} : {1'b0, a[7:0]} + {1'b0, b[7:0]};
    cy = byt ? bs[8] : ws[16];
    sa = byt ? a[7] : a[15];
    sb = byt ? b[7] : b[15];
    sr = byt ? r[7] : r[15];
    ov = sub ? (sa != sb) && (sr != sa) : (sa == sb) && (sr != sa);
    @(posedge I_CLOCK);
    I_ALU_VALID <= 1'b1;
    I_ALU_OP <= op;
    I_ALU_BYTE <= byt;
    I_ALU_SIGNED <= sg;
    I_ALU_A <= a;
    I_ALU_B <= b;
    @(posedge I_CLOCK);
    I_ALU_VALID <= 1'b0;
    #1;
    chk("alu_result", O_ALU_RESULT, r);
    chk("alu_sign", O_ALU_N, byt ? r[7] : r[15]);
    if (op[0] ^ op[1]) chk("alu_less", O_ALU_LESS, lt);
    chk("alu_zero", O_ALU_Z, r == 16'h0000);
    chk("alu_carry", O_ALU_C, cy);
    chk("alu_overflow", O_ALU_V, ov);
  endtask
  task automatic t_char(input logic [15:0] v);
    @(posedge I_CLOCK);
    I_CHAR_OPND <= v;
    @(posedge I_CLOCK);
    #1;
    chk("char_code", O_CHAR_CODE, v[7:0]);
    chk("char_bad", O_CHAR_BAD, v[15:8] != 8'h00);
  endtask
  task automatic t_desc(input logic kind, inl, input logic [15:0] w0, w1, p);
    @(posedge I_CLOCK);
    I_DESC_START <= 1'b1;
    I_DESC_KIND <= kind;
    I_DESC_INLINE <= inl;
    I_GENERAL_REGISTER_N <= w0;
    I_GENERAL_REGISTER_N1 <= w1;
    I_DESC_PTR <= p;
    @(posedge I_CLOCK);
    I_DESC_START <= 1'b0;
    wait_hi(1'b0);
  endtask
  task automatic t_set(input logic [7:0] c, mask, input logic [15:0] base);
    logic [15:0] ad;
    ad = base + {8'h00, c};
    @(posedge I_CLOCK);
    I_SET_START <= 1'b1;
    I_SET_CHAR <= c;
    @(posedge I_CLOCK);
    I_SET_START <= 1'b0;
    wait_hi(1'b1);
    chk("member", O_MEMBER, |(tb_byte(ad) & mask));
  endtask
  // Strings: full length, vacant, then in-line with a slow memory; last a bad set descriptor
  task automatic s_desc;
    t_desc(1'b0, 1'b0, 16'hFFFF, 16'h2345, 16'h0000);
    chk("str_len", O_STR_LEN, 16'hFFFF);
    chk("str_addr", O_STR_ADDR, 16'h2345);
    chk("str_occupied", O_STR_VACANT, 1'b0);
    t_desc(1'b0, 1'b0, 16'h0000, 16'h2345, 16'h0000);
    chk("str_vacant", O_STR_VACANT, 1'b1);
    chk("vacant_addr", O_STR_ADDR, 16'h0000);
    mwait <= 2'h2;
    t_desc(1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0301);
    chk("inl_len", O_STR_LEN, {tb_byte(16'h0301), tb_byte(16'h0300)});
    chk("inl_addr", O_STR_ADDR, {tb_byte(16'h0303), tb_byte(16'h0302)});
    t_desc(1'b1, 1'b0, 16'h0103, 16'h1000, 16'h0000);
    chk("set_bad", O_SET_DESC_BAD, 1'b1);
    chk("set_mask", O_SET_MASK, 8'h03);
    chk("set_base", O_SET_BASE, 16'h1000);
  endtask
  // One subset per mask bit, then none and all; base wraps past the top
  task automatic s_set;
    logic [7:0] m;
    for (int i = 0; i < 10; i++) begin
      m = (i < 8) ? 8'h01 << i : (i == 8 ? 8'h00 : 8'hFF);
      mwait <= i[1:0];
      t_desc(1'b1, 1'b0, {8'h00, m}, 16'hFFC0, 16'h0000);
      chk("set_clean", O_SET_DESC_BAD, 1'b0);
      chk("set_mask_loop", O_SET_MASK, m);
      t_set(8'(i * 37), m, 16'hFFC0);
    end
  endtask
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_ARST_N <= 1'b1;
    @(posedge I_CLOCK);
    for (int i = 0; i < 8; i++) begin
      t_alu(i[2:1], 1'b0, i[0], 16'h7FFF, 16'h8000);
      t_alu(i[2:1], 1'b0, i[0], 16'hFFFF, 16'h0001);
      t_alu(i[2:1], 1'b1, i[0], 16'hAB80, 16'h127F);
    end
    t_char(16'h0041);
    t_char(16'h0141);
    s_desc;
    s_set;
    stop_test;
  end
  // Watchdog, far beyond the roughly 170 cycles the run needs
  initial begin
    #1000000;
    fail_count++;
    stop_test;
  end
endmodule
`default_nettype wire
